// *** bench/tb_top.sv ***
// self-checking bench for the attach/reset host sequencer
`timescale 1ns/1ps
module tb_top;
  import uac_pkg::*;
  localparam int RST_C = 40;
  localparam int RES_C = 40;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, periph = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rd_d, ack_d;
  logic [31:0] dat_o;
  logic ack, pl_i, mi_i, pl_o, pl_oe_n, mi_o, mi_oe_n;
  logic [2:0] mode;
  int err_total = 0, n_checks = 0, exp_mode, exp_ref, len, m;
  always #25 clk = ~clk;
  uac_host_seq #(.RESET_CYC_P(RST_C), .RESUME_CYC_P(RES_C)) u_dut (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .mode_sel_o(mode), .up_plus_i(pl_i), .up_plus_o(pl_o), .up_plus_oe_n_o(pl_oe_n),
    .up_minus_i(mi_i), .up_minus_o(mi_o), .up_minus_oe_n_o(mi_oe_n));
  uac_dev_model u_dev (
    .mode_i(mode), .periph_i(periph), .hp_i(pl_o), .hp_oe_n_i(pl_oe_n), .hm_i(mi_o),
    .hm_oe_n_i(mi_oe_n), .plus_o(pl_i), .minus_o(mi_i));
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_len(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      err_total++;
      $display("MISMATCH t=%0t run of %0d cycles expected %0d", $time, got, exp);
    end
  endtask
  // one classic cycle; only the watchdog ends the wait on a dead slave
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= 4'hf;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    sel <= 4'h0;
    @(posedge clk);
    // ack is a one-cycle pulse, gone in the cycle after it was given
    chk_val({31'h0, ack}, 32'h0);
  endtask
  // waits for a {oe_n, plus, minus} pattern, then counts how long it stands
  task automatic run_len(input logic [2:0] p, output int l);
    int n;
    n = 0;
    l = 0;
    while ({pl_oe_n, pl_o, mi_o} !== p && n < 200) begin
      @(posedge clk);
      n++;
    end
    while ({pl_oe_n, pl_o, mi_o} === p && l < 300) begin
      @(posedge clk);
      l++;
    end
  endtask
  task automatic stat_is(input logic [31:0] mask, input logic [31:0] exp);
    wb(1'b0, STAT_OFS, 32'h0, rd_d);
    chk_val(rd_d & mask, exp);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done;
  end
  initial begin
    m = $urandom(32'h2a5bd3d0);
    exp_mode = 0;
    exp_ref = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_val({29'h0, mode}, 32'h0);
    chk_val({30'h0, pl_oe_n, mi_oe_n}, 32'h3);
    wb(1'b0, CTRL_OFS, 32'h0, rd_d);
    chk_val(rd_d, 32'h0);
    stat_is(32'hffffffff, 32'h0);
    // unmapped place: write ignored, reads zero
    wb(1'b1, 8'h10, 32'hffffffff, ack_d);
    wb(1'b0, 8'h10, 32'h0, rd_d);
    chk_val(rd_d, 32'h0);
    // reserved code first, then random codes with the port setup off
    for (int i = 0; i < 8; i++) begin
      m = (i == 0) ? 4 : int'($urandom % 8);
      wb(1'b1, CTRL_OFS, m, ack_d);
      if (m == 4) exp_ref = 1;
      else exp_mode = m;
      chk_val({29'h0, mode}, exp_mode);
      stat_is(32'h8, exp_ref << 3);
      wb(1'b1, STAT_OFS, 32'h8, ack_d);
      exp_ref = 0;
    end
    // token bridge family: attach, automatic bus reset, recovery
    wb(1'b1, CTRL_OFS, 32'h1e, ack_d);
    periph <= 1'b1;
    run_len(3'b000, len);
    chk_len(len, RST_C);
    repeat (25) @(posedge clk);
    stat_is(32'h3f4, 32'h254);
    // a new code while running is turned away
    wb(1'b1, CTRL_OFS, 32'h1f, ack_d);
    chk_val({29'h0, mode}, 32'h6);
    stat_is(32'h8, 32'h8);
    wb(1'b1, STAT_OFS, 32'hc, ack_d);
    stat_is(32'hc, 32'h0);
    // resume: K then a short SE0, then the lines are let go
    wb(1'b1, CTRL_OFS, 32'h3e, ack_d);
    run_len(3'b001, len);
    chk_len(len, RES_C);
    chk_val({28'h0, pl_oe_n, mi_oe_n, pl_o, mi_o}, 32'h0);
    run_len(3'b000, len);
    chk_len(len, EOP_CYC);
    repeat (25) @(posedge clk);
    stat_is(32'h70, 32'h50);
    // peripheral leaves: pull-up gone, back to waiting
    periph <= 1'b0;
    repeat (60) @(posedge clk);
    stat_is(32'h370, 32'h10);
    wb(1'b1, CTRL_OFS, 32'h6, ack_d);
    @(posedge clk);
    chk_val({30'h0, pl_oe_n, mi_oe_n}, 32'h3);
    stat_is(32'h70, 32'h0);
    test_done;
  end
endmodule

// *** bench/uac_dev_model.sv ***
// behavioural model of the bridge device as seen on the upstream lines
`timescale 1ns/1ps
module uac_dev_model (
  input  wire logic [2:0] mode_i,      // strapped mode code
  input  wire logic       periph_i,    // downstream peripheral pulls its line high
  input  wire logic       hp_i,        // host drive value, plus line
  input  wire logic       hp_oe_n_i,   // host drives plus while low
  input  wire logic       hm_i,        // host drive value, minus line
  input  wire logic       hm_oe_n_i,   // host drives minus while low
  output logic            plus_o,      // resolved up_line_plus
  output logic            minus_o      // resolved up_line_minus
);
  logic att = 1'b0;
  logic pu;
  // a glitch shorter than the window must not count as an attach
  always begin
    @(posedge periph_i);
    #201;
    if (periph_i === 1'b1) att = 1'b1;
  end
  always @(negedge periph_i) att = 1'b0;
  // reserved code has no port setup, so no pull-up is ever engaged
  // code 111 picks its downstream type from supply and pull-downs; upstream is alike
  assign pu = att && (mode_i != 3'h4);
  // released lines settle to the pull-downs unless the pull-up holds plus
  // host SE0 wins over the pull-up and is passed downstream; the attach is kept
  assign plus_o  = !hp_oe_n_i ? hp_i : pu;
  // the model never signals on its own, so no wake-up reaches the host
  assign minus_o = !hm_oe_n_i ? hm_i : 1'b0;
endmodule

// *** inc/uac_line_if.sv ***
// command and sampled line state between sequencer and pin driver
`timescale 1ns/1ps
interface uac_line_if;
  import uac_pkg::*;
  uac_line_t  cmd;
  logic [1:0] seen;  // {plus, minus} as sampled on the pins
  modport ctl (output cmd, input seen);
  modport drv (input cmd, output seen);
endinterface

// *** inc/uac_pkg.sv ***
// shared constants and types of the attach/reset host sequencer
package uac_pkg;
  // register byte offsets on the wishbone port
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;

  // control register fields
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_EN_BIT     = 3;
  localparam int CTRL_AUTO_BIT   = 4;
  localparam int CTRL_RESUME_BIT = 5;

  // status register fields
  localparam int STAT_ATT_BIT    = 0;
  localparam int STAT_RST_BIT    = 1;
  localparam int STAT_DONE_BIT   = 2;
  localparam int STAT_REF_BIT    = 3;
  localparam int STAT_ST_LSB     = 4;
  localparam int STAT_SEEN_LSB   = 8;

  // mode strap codes
  localparam logic [2:0] MODE_RST_VAL  = 3'h0;
  localparam logic [2:0] MODE_RESERVED = 3'h4;

  // timing
  localparam int unsigned CLK_NS      = 50;
  localparam int unsigned ATTACH_NS   = 200;
  localparam int unsigned RECOVER_NS  = 1000;
  localparam int unsigned DETACH_NS   = 2500;
  localparam int unsigned EOP_NS      = 167;
  localparam int unsigned RESET_US    = 10;
  localparam int unsigned RESUME_US   = 20000;
  localparam int unsigned ATTACH_CYC  = (ATTACH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DETACH_CYC  = (DETACH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned EOP_CYC     = (EOP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RESET_CYC   = RESET_US * 1000 / CLK_NS;
  localparam int unsigned RESUME_CYC  = RESUME_US * 1000 / CLK_NS;
  localparam int unsigned CNT_W       = 20;

  typedef enum logic [1:0] {LN_REL, LN_SE0, LN_J, LN_K} uac_line_t;

  typedef enum logic [2:0] {
    ST_OFF, ST_WAIT, ST_ATT, ST_RESET, ST_RECOVER, ST_READY, ST_RESUME, ST_EOP
  } uac_st_t;
endpackage

// *** rtl/uac_host_seq.sv ***
// host-side controller: mode strap, attach watch, bus reset and resume
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
module uac_host_seq #(
  parameter int unsigned RESET_CYC_P  = uac_pkg::RESET_CYC,  // SE0 reset length
  parameter int unsigned RESUME_CYC_P = uac_pkg::RESUME_CYC  // resume K length
) (
  input  wire logic        clk_i,           // 20 MHz clock
  input  wire logic        rst_i,           // synchronous reset, active high
  input  wire logic        wb_cyc_i,        // wishbone cycle
  input  wire logic        wb_stb_i,        // wishbone strobe
  input  wire logic        wb_we_i,         // wishbone write
  input  wire logic [7:0]  wb_adr_i,        // byte address
  input  wire logic [3:0]  wb_sel_i,        // byte lanes
  input  wire logic [31:0] wb_dat_i,        // write data
  output logic      [31:0] wb_dat_o,        // read data
  output logic             wb_ack_o,        // acknowledge
  output logic      [2:0]  mode_sel_o,      // mode strap to the device
  input  wire logic        up_plus_i,       // up_line_plus level
  output logic             up_plus_o,       // up_line_plus drive value
  output logic             up_plus_oe_n_o,  // low while driving up_line_plus
  input  wire logic        up_minus_i,      // up_line_minus level
  output logic             up_minus_o,      // up_line_minus drive value
  output logic             up_minus_oe_n_o  // low while driving up_line_minus
);
  import uac_pkg::*;

  localparam logic [CNT_W-1:0] ATT_END = CNT_W'(ATTACH_CYC - 1);
  localparam logic [CNT_W-1:0] REC_END = CNT_W'(RECOVER_CYC - 1);
  localparam logic [CNT_W-1:0] DET_END = CNT_W'(DETACH_CYC - 1);
  localparam logic [CNT_W-1:0] EOP_END = CNT_W'(EOP_CYC - 1);
  localparam logic [CNT_W-1:0] RST_END = CNT_W'(RESET_CYC_P - 1);
  localparam logic [CNT_W-1:0] RES_END = CNT_W'(RESUME_CYC_P - 1);

  typedef struct packed {
    uac_st_t          st;
    logic [CNT_W-1:0] cnt;
    logic [2:0]       mode;
    logic             en;
    logic             auto_rst;
    logic             resume_req;
    logic             attached;
    logic             rst_done;
    logic             refused;
    logic             ack;
    logic [31:0]      dat;
    uac_line_t        cmd;
  } uac_main_t;

  uac_main_t  r;
  uac_main_t  n;
  uac_line_if line ();

  logic       wb_hit;
  logic       wr;
  logic [2:0] wr_mode;
  logic       plus_up;

  assign wb_hit  = wb_cyc_i && wb_stb_i && !r.ack;
  assign wr      = wb_hit && wb_we_i && wb_sel_i[0];
  assign wr_mode = wb_dat_i[CTRL_MODE_LSB +: 3];
  assign plus_up = line.seen == 2'b10;

  always_comb begin
    n     = r;
    n.ack = wb_hit;
    // register access first, so hardware events below win over clears
    if (wr && wb_adr_i == CTRL_OFS) begin
      // the strap may only move while the sequencer is off or being stopped
      if (wr_mode == MODE_RESERVED || (r.en && wb_dat_i[CTRL_EN_BIT])) begin
        if (wr_mode != r.mode) begin
          n.refused = 1'b1;
        end
      end else begin
        n.mode = wr_mode;
      end
      n.en       = wb_dat_i[CTRL_EN_BIT];
      n.auto_rst = wb_dat_i[CTRL_AUTO_BIT];
      if (wb_dat_i[CTRL_RESUME_BIT]) begin
        n.resume_req = 1'b1;
      end
    end
    if (wr && wb_adr_i == STAT_OFS) begin
      if (wb_dat_i[STAT_DONE_BIT]) begin
        n.rst_done = 1'b0;
      end
      if (wb_dat_i[STAT_REF_BIT] && !(wr && wb_adr_i == CTRL_OFS)) begin
        n.refused = 1'b0;
      end
    end
    if (wb_hit && !wb_we_i) begin
      case (wb_adr_i)
        CTRL_OFS: n.dat = {26'h0, r.resume_req, r.auto_rst, r.en, r.mode};
        STAT_OFS: n.dat = {22'h0, line.seen, 1'b0, r.st, r.refused, r.rst_done,
                           (r.st == ST_RESET), r.attached};
        default:  n.dat = 32'h0;
      endcase
    end

    n.cnt = r.cnt + CNT_W'(1);
    case (r.st)
      ST_OFF: begin
        n.cmd = LN_REL;
        n.cnt = '0;
        if (r.en) begin
          n.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        n.cmd = LN_REL;
        if (!plus_up) begin
          n.cnt = '0;
        end else if (r.cnt == ATT_END) begin
          n.st       = ST_ATT;
          n.attached = 1'b1;
          n.cnt      = '0;
        end
      end
      ST_ATT: begin
        n.cnt = '0;
        if (r.auto_rst) begin
          n.st  = ST_RESET;
          n.cmd = LN_SE0;
        end
      end
      ST_RESET: begin
        n.cmd = LN_SE0;
        if (r.cnt == RST_END) begin
          n.st  = ST_RECOVER;
          n.cmd = LN_REL;
          n.cnt = '0;
        end
      end
      ST_RECOVER: begin
        // the device pulls the line back up on its own after release
        if (plus_up) begin
          n.st       = ST_READY;
          n.rst_done = 1'b1;
          n.cnt      = '0;
        end else if (r.cnt == REC_END) begin
          n.st       = ST_WAIT;
          n.attached = 1'b0;
          n.cnt      = '0;
        end
      end
      ST_READY: begin
        if (r.resume_req) begin
          n.st         = ST_RESUME;
          n.cmd        = LN_K;
          // a request written in this very cycle is kept: the set wins over the clear
          n.resume_req = wr && wb_adr_i == CTRL_OFS && wb_dat_i[CTRL_RESUME_BIT];
          n.cnt        = '0;
        end else if (plus_up) begin
          n.cnt = '0;
        end else if (r.cnt == DET_END) begin
          n.st       = ST_WAIT;
          n.attached = 1'b0;
          n.cnt      = '0;
        end
      end
      ST_RESUME: begin
        n.cmd = LN_K;
        if (r.cnt == RES_END) begin
          n.st  = ST_EOP;
          n.cmd = LN_SE0;
          n.cnt = '0;
        end
      end
      ST_EOP: begin
        n.cmd = LN_SE0;
        if (r.cnt == EOP_END) begin
          n.st  = ST_READY;
          n.cmd = LN_REL;
          n.cnt = '0;
        end
      end
      default: begin
        n.st  = ST_OFF;
        n.cmd = LN_REL;
      end
    endcase
    if (!r.en) begin
      n.st       = ST_OFF;
      n.cmd      = LN_REL;
      n.attached = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '{st: ST_OFF, cnt: '0, mode: MODE_RST_VAL, en: 1'b0, auto_rst: 1'b0,
             resume_req: 1'b0, attached: 1'b0, rst_done: 1'b0, refused: 1'b0,
             ack: 1'b0, dat: 32'h0, cmd: LN_REL};
    end else begin
      r <= n;
    end
  end

  assign line.cmd   = r.cmd;
  assign wb_dat_o   = r.dat;
  assign wb_ack_o   = r.ack;
  assign mode_sel_o = r.mode;

  uac_line_drv u_drv (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .line            (line),
    .up_plus_i       (up_plus_i),
    .up_minus_i      (up_minus_i),
    .up_plus_o       (up_plus_o),
    .up_plus_oe_n_o  (up_plus_oe_n_o),
    .up_minus_o      (up_minus_o),
    .up_minus_oe_n_o (up_minus_oe_n_o)
  );

  sequence s_reset_end;
    (r.st == ST_RESET) ##1 (r.st == ST_RECOVER);
  endsequence
  sequence s_attach_seen;
    plus_up [*4] ##1 (r.st == ST_ATT);
  endsequence

  a_mode_not_rsvd: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_sel_o != MODE_RESERVED)
    else $error("reserved mode code on the strap");
  a_strap_steady: assert property (@(posedge clk_i) disable iff (rst_i)
    r.en && $past(r.en) && !$past(rst_i) |-> $stable(mode_sel_o))
    else $error("strap moved while sequencer running");
  a_reset_needs_att: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(r.st == ST_RESET) |-> r.attached && $past(r.st) == ST_ATT)
    else $error("bus reset without a seen attach");
  a_reset_drives_se0: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.st == ST_RESET) |-> r.cmd == LN_SE0)
    else $error("reset state without SE0 command");
  a_reset_release: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reset_end |-> r.cmd == LN_REL && $past(r.cnt) == RST_END)
    else $error("SE0 not released at the reset length");
  a_attach_qual: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(r.st == ST_ATT) |-> $past(r.cnt) == ATT_END && $past(plus_up))
    else $error("attach taken without the full high time");
  a_attach_timing: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.st == ST_WAIT && r.en) ##0 s_attach_seen |-> r.attached)
    else $error("attach flag missing after qualified high");
  a_resume_is_k: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.st == ST_RESUME) |-> r.cmd == LN_K ##1 (r.st != ST_RESUME || r.cmd == LN_K))
    else $error("resume not signalled as K");
endmodule

// *** rtl/uac_line_drv.sv ***
// upstream line pin driver: turns a line command into pin levels
`timescale 1ns/1ps
module uac_line_drv (
  input  wire logic clk_i,          // 20 MHz clock
  input  wire logic rst_i,          // synchronous reset
  uac_line_if.drv   line,           // command in, sampled lines out
  input  wire logic up_plus_i,      // up_line_plus level
  input  wire logic up_minus_i,     // up_line_minus level
  output logic      up_plus_o,      // up_line_plus drive value
  output logic      up_plus_oe_n_o, // low while driving up_line_plus
  output logic      up_minus_o,     // up_line_minus drive value
  output logic      up_minus_oe_n_o // low while driving up_line_minus
);
  import uac_pkg::*;

  typedef struct packed {
    logic [1:0] out;
    logic       oe_n;
    logic [1:0] seen;
  } uac_drv_t;

  uac_drv_t drv_reg;
  uac_drv_t drv_next;

  always_comb begin
    drv_next      = drv_reg;
    drv_next.seen = {up_plus_i, up_minus_i};
    drv_next.oe_n = 1'b0;
    case (line.cmd)
      LN_SE0:  drv_next.out = 2'b00;
      LN_J:    drv_next.out = 2'b10;
      LN_K:    drv_next.out = 2'b01;
      default: begin
        drv_next.out  = 2'b00;
        drv_next.oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drv_reg <= '{out: 2'b00, oe_n: 1'b1, seen: 2'b00};
    end else begin
      drv_reg <= drv_next;
    end
  end

  assign up_plus_o       = drv_reg.out[1];
  assign up_minus_o      = drv_reg.out[0];
  assign up_plus_oe_n_o  = drv_reg.oe_n;
  assign up_minus_oe_n_o = drv_reg.oe_n;
  assign line.seen       = drv_reg.seen;

  a_j_encoding: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(line.cmd) == LN_J && !$past(rst_i) |-> !drv_reg.oe_n && drv_reg.out == 2'b10)
    else $error("J not driven as plus high, minus low");
  a_k_encoding: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(line.cmd) == LN_K && !$past(rst_i) |-> !drv_reg.oe_n && drv_reg.out == 2'b01)
    else $error("K not driven as plus low, minus high");
endmodule
